// >>> hdl/bcu_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the bridge control block
// Assumes: Included by bare name from the package and the design modules
// Notes: Definitions only
`ifndef BCU_CONSTS_SVH
`define BCU_CONSTS_SVH

// ======================================================================
// Bus shape
`define BCU_ADDR_W 12
`define BCU_DATA_W 32

// ======================================================================
// Register byte addresses
`define BCU_OFF_CTRL 12'h03C
`define BCU_OFF_IRQ_STAT 12'h044
`define BCU_OFF_IRQ_MASK 12'h048
`define BCU_OFF_TMR_STAT 12'h04C

// ======================================================================
// Control word field positions
`define BCU_BIT_SEC_RESET 22
`define BCU_BIT_FAST_B2B 23
`define BCU_BIT_PRI_SHORT 24
`define BCU_BIT_SEC_SHORT 25
`define BCU_BIT_TMO_STAT 26
`define BCU_BIT_DISC_SERR_EN 27
`define BCU_CTRL_RESET 32'h0000_0000

// ======================================================================
// Interrupt and timer status layout
`define BCU_NUM_SIDES 2
`define BCU_SIDE_PRI 0
`define BCU_SIDE_SEC 1
`define BCU_IRQ_MASK_RESET 2'h0
`define BCU_TMR_EXP_LSB 2

// ======================================================================
// Timeouts, as log2 of the count of PCI clocks (one clk_i cycle each)
`define BCU_TMO_LONG_EXP 15
`define BCU_TMO_SHORT_EXP 10
`define BCU_CNT_W 16

`endif

// >>> hdl/bcu_pkg.sv
// Purpose: Types shared by the bridge control block
// Assumes: Constants come from bcu_consts.svh
// Notes: Nothing here is imported; users write bcu_pkg::name
`include "bcu_consts.svh"

package bcu_pkg;

    // APB slave phase tracker
    typedef enum logic [1:0] {
        BCU_APB_IDLE = 2'b00,
        BCU_APB_WAIT = 2'b01,
        BCU_APB_DONE = 2'b10
    } bcu_apb_e;

    // Per-side event vector
    typedef logic [`BCU_NUM_SIDES-1:0] bcu_side_t;

endpackage

// >>> hdl/bcu_dt_timer.sv
// Purpose: Delayed transaction repeat timer for one bus side
// Assumes: head_i is a level from the queue, repeat_i a one-cycle pulse
// Notes: At most one expiry pulse per transaction at the head of the queue, none once repeated
`timescale 1ns/1ps
`default_nettype none
`include "bcu_consts.svh"

module bcu_dt_timer #(
    parameter int unsigned LONG_CYC = 32768,
    parameter int unsigned SHORT_CYC = 1024
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic short_sel_i,
    input wire logic head_i,
    input wire logic repeat_i,
    output logic running_o,
    output logic expire_o
);

    // ==================================================================
    // Counter state
    logic [`BCU_CNT_W-1:0] cnt_q; // Cycles since reaching the head
    logic done_q; // Repeated or expired; stop until head drops
    logic expire_q; // Expiry pulse
    wire logic [`BCU_CNT_W-1:0] last_w; // Terminal count for this side
    wire logic run_w; // Counting this cycle
    wire logic hit_w; // Terminal count reached

    assign last_w = short_sel_i ? `BCU_CNT_W'(SHORT_CYC - 1) : `BCU_CNT_W'(LONG_CYC - 1);
    assign run_w = head_i && !done_q && !repeat_i;
    assign hit_w = run_w && (cnt_q >= last_w);

    // Count from the first head cycle, stop on repeat, fire once
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            done_q <= 1'b0;
            expire_q <= 1'b0;
        end else if (ce_i) begin
            expire_q <= hit_w;
            if (!head_i) begin
                cnt_q <= '0;
                done_q <= 1'b0;
            end else if (repeat_i || hit_w) begin
                done_q <= 1'b1;
            end else if (run_w) begin
                cnt_q <= cnt_q + `BCU_CNT_W'(1);
            end
        end
    end

    assign running_o = run_w;
    assign expire_o = expire_q;

endmodule
`default_nettype wire

// >>> hdl/bcu_evt_irq.sv
// Purpose: Sticky event status with mask and one level interrupt
// Assumes: rd_clr_i pulses on the completing edge of a status read
// Notes: An event in the clearing cycle stays set
`timescale 1ns/1ps
`default_nettype none
`include "bcu_consts.svh"

module bcu_evt_irq (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [`BCU_NUM_SIDES-1:0] evt_i,
    input wire logic rd_clr_i,
    input wire logic [`BCU_NUM_SIDES-1:0] mask_i,
    output logic [`BCU_NUM_SIDES-1:0] status_o,
    output logic irq_o
);

    // ==================================================================
    // Status bits
    logic [`BCU_NUM_SIDES-1:0] stat_q; // Sticky events
    logic [`BCU_NUM_SIDES-1:0] stat_d; // Next sticky events
    logic irq_q; // Registered interrupt level

    genvar g;
    generate
        for (g = 0; g < `BCU_NUM_SIDES; g++) begin : g_bit
            // Set wins over the read clear
            assign stat_d[g] = evt_i[g] | (stat_q[g] & ~rd_clr_i);
        end
    endgenerate

    // Hold status and interrupt level
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            stat_q <= '0;
            irq_q <= 1'b0;
        end else if (ce_i) begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_i);
        end
    end

    assign status_o = stat_q;
    assign irq_o = irq_q;

endmodule
`default_nettype wire

// >>> hdl/bcu_top.sv
// Purpose: Upper bridge control bits, delayed transaction timers, APB slave
// Assumes: clk_i is the PCI clock; all inputs synchronous to it
// Notes: Bits 21..16 of the control word are not held here and read zero
//
// How it works
// - bit 22 drives secondary reset output
// - bit 23 permits fast back-to-back cycles
// - bit 24 picks primary timeout length
// - bit 25 picks secondary timeout length
// - timer starts when transaction reaches head
// - unrepeated transaction dropped on expiry
// - bit 26 set on expiry, write-one clears
// - bit 27 enables system error on expiry
// - bits 31..28 read zero always
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bcu_consts.svh"

module bcu_top #(
    parameter int unsigned LONG_CYC = (1 << `BCU_TMO_LONG_EXP),
    parameter int unsigned SHORT_CYC = (1 << `BCU_TMO_SHORT_EXP)
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`BCU_ADDR_W-1:0] paddr_i,
    input wire logic [`BCU_DATA_W-1:0] pwdata_i,
    output logic pready_o,
    output logic [`BCU_DATA_W-1:0] prdata_o,
    output logic pslverr_o,
    // Delayed transaction queues, bit 0 primary, bit 1 secondary
    input wire logic [`BCU_NUM_SIDES-1:0] dt_head_i,
    input wire logic [`BCU_NUM_SIDES-1:0] dt_repeat_i,
    output logic [`BCU_NUM_SIDES-1:0] dt_discard_o,
    // Secondary bus side
    output logic sec_bus_reset_n_o,
    output logic fast_b2b_en_o,
    // Primary side error and interrupt
    output logic primary_system_error_out_n_o,
    output logic irq_o
);

    // ==================================================================
    // Control register fields
    logic sec_reset_q; // Force secondary reset
    logic fast_b2b_q; // Fast back-to-back permitted
    logic pri_short_q; // Primary short timeout
    logic sec_short_q; // Secondary short timeout
    logic tmo_stat_q; // Timeout seen
    logic disc_serr_q; // Error on discard enabled
    logic tmo_stat_d; // Next timeout seen

    // ==================================================================
    // Interrupt mask and output flops
    logic [`BCU_NUM_SIDES-1:0] irq_mask_q; // Interrupt mask
    logic [`BCU_NUM_SIDES-1:0] discard_q; // Discard pulses out
    logic sec_rst_n_q; // Secondary reset pin level
    logic fast_b2b_out_q; // Fast back-to-back pin level
    logic serr_n_q; // System error pin level

    // ==================================================================
    // APB slave state
    bcu_pkg::bcu_apb_e apb_q; // Phase of the current access
    bcu_pkg::bcu_apb_e apb_d; // Next phase
    logic pready_q; // Completion strobe
    logic pslverr_q; // Unmapped address answer
    logic [`BCU_DATA_W-1:0] prdata_q; // Captured read data

    // ==================================================================
    // Timer and event wires
    wire bcu_pkg::bcu_side_t short_sel_w; // Timeout selection per side
    wire bcu_pkg::bcu_side_t running_w; // Timer counting per side
    wire bcu_pkg::bcu_side_t expire_w; // Timer expiry pulses
    wire bcu_pkg::bcu_side_t irq_stat_w; // Sticky event status
    wire logic irq_w; // Interrupt from the status block
    wire logic any_exp_w; // Either side expired

    // ==================================================================
    // Address decode
    wire logic access_w; // Access phase present
    wire logic complete_w; // Transfer completes at this edge
    wire logic hit_ctrl_w; // Control word selected
    wire logic hit_stat_w; // Interrupt status selected
    wire logic hit_mask_w; // Interrupt mask selected
    wire logic hit_tmr_w; // Timer status selected
    wire logic hit_any_w; // Any register selected
    wire logic wr_ctrl_w; // Control word write
    wire logic wr_mask_w; // Mask write
    wire logic rd_stat_w; // Status read completes
    wire logic [`BCU_DATA_W-1:0] ctrl_rd_w; // Control word view
    wire logic [`BCU_DATA_W-1:0] stat_rd_w; // Interrupt status view
    wire logic [`BCU_DATA_W-1:0] mask_rd_w; // Mask view
    wire logic [`BCU_DATA_W-1:0] tmr_rd_w; // Timer status view
    wire logic [`BCU_DATA_W-1:0] rd_mux_w; // Selected read data

    assign access_w = psel_i && penable_i;
    assign complete_w = access_w && pready_q;
    assign hit_ctrl_w = (paddr_i == `BCU_OFF_CTRL);
    assign hit_stat_w = (paddr_i == `BCU_OFF_IRQ_STAT);
    assign hit_mask_w = (paddr_i == `BCU_OFF_IRQ_MASK);
    assign hit_tmr_w = (paddr_i == `BCU_OFF_TMR_STAT);
    assign hit_any_w = hit_ctrl_w || hit_stat_w || hit_mask_w || hit_tmr_w;
    assign wr_ctrl_w = complete_w && pwrite_i && hit_ctrl_w;
    assign wr_mask_w = complete_w && pwrite_i && hit_mask_w;
    assign rd_stat_w = complete_w && !pwrite_i && hit_stat_w;

    // ==================================================================
    // Read views; every bit not named reads zero
    assign ctrl_rd_w = {
        4'h0,
        disc_serr_q,
        tmo_stat_q,
        sec_short_q,
        pri_short_q,
        fast_b2b_q,
        sec_reset_q,
        22'h00_0000
    };
    assign stat_rd_w = {{(`BCU_DATA_W - `BCU_NUM_SIDES){1'b0}}, irq_stat_w};
    assign mask_rd_w = {{(`BCU_DATA_W - `BCU_NUM_SIDES){1'b0}}, irq_mask_q};
    assign tmr_rd_w = {
        {(`BCU_DATA_W - 2 * `BCU_NUM_SIDES){1'b0}},
        discard_q,
        running_w
    };
    assign rd_mux_w = hit_ctrl_w ? ctrl_rd_w :
                      hit_stat_w ? stat_rd_w :
                      hit_mask_w ? mask_rd_w :
                      hit_tmr_w ? tmr_rd_w : 32'h0000_0000;

    // ==================================================================
    // APB phase sequencing: one wait cycle, then pready
    always_comb begin
        apb_d = apb_q;
        unique case (apb_q)
            bcu_pkg::BCU_APB_IDLE: begin
                // First access cycle seen, answer next
                if (access_w) begin
                    apb_d = bcu_pkg::BCU_APB_WAIT;
                end
            end
            bcu_pkg::BCU_APB_WAIT: begin
                // pready is high now; transfer completes
                apb_d = bcu_pkg::BCU_APB_DONE;
            end
            bcu_pkg::BCU_APB_DONE: begin
                // Gap cycle before the next access
                apb_d = bcu_pkg::BCU_APB_IDLE;
            end
            default: begin
                // Illegal code recovers to idle
                apb_d = bcu_pkg::BCU_APB_IDLE;
            end
        endcase
    end

    // Phase register and registered answer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            apb_q <= bcu_pkg::BCU_APB_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            apb_q <= apb_d;
            pready_q <= (apb_d == bcu_pkg::BCU_APB_WAIT);
            pslverr_q <= (apb_d == bcu_pkg::BCU_APB_WAIT) && !hit_any_w;
            // Read data captured ahead of the completing edge
            if (apb_q == bcu_pkg::BCU_APB_IDLE && access_w && !pwrite_i) begin
                prdata_q <= rd_mux_w;
            end else if (apb_d != bcu_pkg::BCU_APB_WAIT) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ==================================================================
    // Control word: write-one clear of the timeout flag, set wins
    assign any_exp_w = |expire_w;
    assign tmo_stat_d = any_exp_w || (tmo_stat_q && !(wr_ctrl_w && pwdata_i[`BCU_BIT_TMO_STAT]));

    // Software-written control bits
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sec_reset_q <= 1'(`BCU_CTRL_RESET >> `BCU_BIT_SEC_RESET);
            fast_b2b_q <= 1'b0;
            pri_short_q <= 1'b0;
            sec_short_q <= 1'b0;
            disc_serr_q <= 1'b0;
        end else if (ce_i && wr_ctrl_w) begin
            sec_reset_q <= pwdata_i[`BCU_BIT_SEC_RESET];
            fast_b2b_q <= pwdata_i[`BCU_BIT_FAST_B2B];
            pri_short_q <= pwdata_i[`BCU_BIT_PRI_SHORT];
            sec_short_q <= pwdata_i[`BCU_BIT_SEC_SHORT];
            disc_serr_q <= pwdata_i[`BCU_BIT_DISC_SERR_EN];
        end
    end

    // Timeout flag register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tmo_stat_q <= 1'b0;
        end else if (ce_i) begin
            tmo_stat_q <= tmo_stat_d;
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_mask_q <= `BCU_IRQ_MASK_RESET;
        end else if (ce_i && wr_mask_w) begin
            irq_mask_q <= pwdata_i[`BCU_NUM_SIDES-1:0];
        end
    end

    // ==================================================================
    // Per-side repeat timers
    assign short_sel_w[`BCU_SIDE_PRI] = pri_short_q;
    assign short_sel_w[`BCU_SIDE_SEC] = sec_short_q;

    genvar s;
    generate
        for (s = 0; s < `BCU_NUM_SIDES; s++) begin : g_side
            bcu_dt_timer #(
                .LONG_CYC(LONG_CYC),
                .SHORT_CYC(SHORT_CYC)
            ) u_timer (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .ce_i(ce_i),
                .short_sel_i(short_sel_w[s]),
                .head_i(dt_head_i[s]),
                .repeat_i(dt_repeat_i[s]),
                .running_o(running_w[s]),
                .expire_o(expire_w[s])
            );
        end
    endgenerate

    // ==================================================================
    // Expiry events into sticky status and interrupt
    bcu_evt_irq u_irq (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .evt_i(expire_w),
        .rd_clr_i(rd_stat_w),
        .mask_i(irq_mask_q),
        .status_o(irq_stat_w),
        .irq_o(irq_w)
    );

    // ==================================================================
    // Output pins, each from its own flop
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sec_rst_n_q <= 1'b1;
            fast_b2b_out_q <= 1'b0;
            serr_n_q <= 1'b1;
            discard_q <= '0;
        end else if (ce_i) begin
            // Reset held low while the control bit is set
            sec_rst_n_q <= !sec_reset_q;
            // Fast back-to-back only when enabled
            fast_b2b_out_q <= fast_b2b_q;
            // One-cycle error pulse for each cycle in which either side expires, when enabled
            serr_n_q <= !(disc_serr_q && any_exp_w);
            // Drop the unrepeated transaction from its queue
            discard_q <= expire_w;
        end
    end

    assign pready_o = pready_q;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;
    assign dt_discard_o = discard_q;
    assign sec_bus_reset_n_o = sec_rst_n_q;
    assign fast_b2b_en_o = fast_b2b_out_q;
    assign primary_system_error_out_n_o = serr_n_q;
    assign irq_o = irq_w;

endmodule
`default_nettype wire

// >>> bench/bcu_top_props.sv
// Purpose: Port checker for the bridge control block
// Assumes: ce_i is held high by the bench
// Notes: Bound to bcu_top after the module
`timescale 1ns/1ps
`default_nettype none
`include "bcu_consts.svh"

module bcu_top_props #(
    parameter int unsigned LONG_CYC = 32768,
    parameter int unsigned SHORT_CYC = 1024
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`BCU_ADDR_W-1:0] paddr_i,
    input wire logic [`BCU_DATA_W-1:0] pwdata_i,
    input wire logic pready_o,
    input wire logic [`BCU_DATA_W-1:0] prdata_o,
    input wire logic [`BCU_NUM_SIDES-1:0] dt_head_i,
    input wire logic [`BCU_NUM_SIDES-1:0] dt_repeat_i,
    input wire logic [`BCU_NUM_SIDES-1:0] dt_discard_o,
    input wire logic sec_bus_reset_n_o,
    input wire logic fast_b2b_en_o,
    input wire logic primary_system_error_out_n_o,
    input wire logic irq_o
);
    // ==========
    // Shadow state
    wire hit_ctrl = psel_i && penable_i && pready_o && (paddr_i == `BCU_OFF_CTRL);
    wire wr_ctrl = hit_ctrl && pwrite_i; // Completing control write
    wire rd_ctrl = hit_ctrl && !pwrite_i; // Completing control read
    logic [5:0] cfg_q; // Mirror of bits 27..22
    logic stat_q; // Expected timeout status
    int unsigned cnt_q [2]; // Cycles since head rose
    logic [1:0] rep_q; // Repeat seen in this head period
    wire [1:0] due; // Discard expected now
    assign due[0] = (cnt_q[0] == (cfg_q[2] ? SHORT_CYC : LONG_CYC) + 1) && !rep_q[0];
    assign due[1] = (cnt_q[1] == (cfg_q[3] ? SHORT_CYC : LONG_CYC) + 1) && !rep_q[1];
    // Follow writes, expiries and head periods
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cfg_q <= 6'h00;
            stat_q <= 1'b0;
            cnt_q <= '{default: 0};
            rep_q <= 2'h0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                cfg_q <= pwdata_i[27:22];
            end
            if (|dt_discard_o) begin
                stat_q <= 1'b1;
            end else if (wr_ctrl && pwdata_i[26]) begin
                stat_q <= 1'b0;
            end
            for (int s = 0; s < 2; s++) begin
                cnt_q[s] <= dt_head_i[s] ? cnt_q[s] + 1 : 0;
                rep_q[s] <= dt_head_i[s] && (rep_q[s] || dt_repeat_i[s]);
            end
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_sec_rst; sec_bus_reset_n_o == !$past(cfg_q[0]); endproperty
    a_sec_rst: assert property (p_sec_rst) else $error("sec reset pin wrong");
    property p_fast; wr_ctrl |=> ##1 fast_b2b_en_o == $past(pwdata_i[23], 2); endproperty
    a_fast: assert property (p_fast) else $error("fast b2b pin wrong");
    property p_pri_tmo; dt_discard_o[0] == due[0]; endproperty
    a_pri_tmo: assert property (p_pri_tmo) else $error("primary discard wrong");
    property p_sec_tmo; dt_discard_o[1] == due[1]; endproperty
    a_sec_tmo: assert property (p_sec_tmo) else $error("secondary discard wrong");
    property p_stat; rd_ctrl |-> prdata_o[26] == $past(stat_q || |dt_discard_o); endproperty
    a_stat: assert property (p_stat) else $error("timeout status wrong");
    property p_serr; !primary_system_error_out_n_o == (|dt_discard_o && $past(cfg_q[5])); endproperty
    a_serr: assert property (p_serr) else $error("error pulse wrong");
    property p_rsvd; rd_ctrl |-> prdata_o[31:28] == 4'h0 && prdata_o[27] == cfg_q[5]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("top nibble not zero");
    property p_apb; psel_i && penable_i && !$past(penable_i) |-> !pready_o ##1 pready_o; endproperty
    a_apb: assert property (p_apb) else $error("apb wait wrong");
    property p_irq; $rose(irq_o) |-> |dt_discard_o; endproperty
    a_irq: assert property (p_irq) else $error("irq rose without expiry");
    c_pri: cover property (dt_discard_o[0]);
    c_sec: cover property (dt_discard_o[1]);
    c_serr: cover property (!primary_system_error_out_n_o);
endmodule

bind bcu_top bcu_top_props #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .dt_head_i(dt_head_i),
    .dt_repeat_i(dt_repeat_i), .dt_discard_o(dt_discard_o),
    .sec_bus_reset_n_o(sec_bus_reset_n_o), .fast_b2b_en_o(fast_b2b_en_o),
    .primary_system_error_out_n_o(primary_system_error_out_n_o), .irq_o(irq_o)
);
`default_nettype wire

// >>> bench/bcu_pci_init.sv
// Purpose: Initiators on both buses owning delayed requests
// Assumes: One request per side at a time
// Notes: rep_dly_i of zero means never repeated
`timescale 1ns/1ps
`default_nettype none

module bcu_pci_init (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] start_i,
    input wire logic [15:0] rep_dly_i,
    input wire logic [1:0] dt_discard_i,
    output logic [1:0] dt_head_o,
    output logic [1:0] dt_repeat_o
);
    logic [15:0] age_q [2]; // Cycles a request has waited
    wire rep_on = rep_dly_i != 16'h0000; // Initiator will repeat
    // ==========
    // Request life per side
    always_ff @(posedge clk_i) begin
        for (int s = 0; s < 2; s++) begin
            dt_repeat_o[s] <= 1'b0;
            if (!resetn_i || dt_discard_i[s]) begin
                dt_head_o[s] <= 1'b0;
                age_q[s] <= 16'h0000;
            end else if (start_i[s]) begin
                dt_head_o[s] <= 1'b1;
                age_q[s] <= 16'h0000;
            end else if (dt_head_o[s]) begin
                age_q[s] <= age_q[s] + 16'h0001;
                // Repeat once, then complete a few cycles later
                dt_repeat_o[s] <= rep_on && (age_q[s] == rep_dly_i);
                dt_head_o[s] <= !(rep_on && (age_q[s] == rep_dly_i + 16'h0004));
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/bcu_top_tb.sv
// Purpose: Self-checking bench for the bridge control block
// Assumes: Timeout counts shortened to 64 and 16 cycles
// Notes: ce_i is held high
`timescale 1ns/1ps
`default_nettype none
`include "bcu_consts.svh"

module bcu_top_tb;
    localparam int LCYC = 64; // Long timeout used here
    localparam int SCYC = 16; // Short timeout used here
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [`BCU_ADDR_W-1:0] paddr_i = '0;
    logic [`BCU_DATA_W-1:0] pwdata_i = '0;
    logic [`BCU_DATA_W-1:0] prdata_o;
    logic pready_o, pslverr_o, sec_bus_reset_n_o, fast_b2b_en_o;
    logic primary_system_error_out_n_o, irq_o;
    logic [1:0] dt_head, dt_repeat, dt_discard;
    logic [1:0] start = 2'h0;
    logic [15:0] rep_dly = 16'h0000;
    int n_fail = 0;
    int compares = 0;
    // Clock at 200 MHz
    always #2.5 clk_i = ~clk_i;
    bcu_top #(.LONG_CYC(LCYC), .SHORT_CYC(SCYC)) uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .dt_head_i(dt_head), .dt_repeat_i(dt_repeat), .dt_discard_o(dt_discard),
        .sec_bus_reset_n_o(sec_bus_reset_n_o), .fast_b2b_en_o(fast_b2b_en_o),
        .primary_system_error_out_n_o(primary_system_error_out_n_o), .irq_o(irq_o)
    );
    bcu_pci_init u_init (
        .clk_i(clk_i), .resetn_i(resetn_i), .start_i(start), .rep_dly_i(rep_dly),
        .dt_discard_i(dt_discard), .dt_head_o(dt_head), .dt_repeat_o(dt_repeat)
    );
    // ==========
    // Shared tasks
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer, entered and left at a rising edge
    task automatic apb(input logic w, input logic [`BCU_ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // ==========
    // Scenarios
    task automatic t_ctrl();
        logic [31:0] d;
        logic e;
        apb(1'b0, `BCU_OFF_CTRL, 32'h0, d, e);
        chk("ctrl reset", 32'h0000_0000, d);
        chk("irq reset", 32'h0, irq_o);
        apb(1'b1, `BCU_OFF_CTRL, 32'hFFFF_FFFF, d, e);
        apb(1'b0, `BCU_OFF_CTRL, 32'h0, d, e);
        chk("ctrl all ones", 32'h0BC0_0000, d);
        chk("sec reset on", 32'h0, sec_bus_reset_n_o);
        chk("fast b2b on", 32'h1, fast_b2b_en_o);
        apb(1'b1, `BCU_OFF_CTRL, 32'h0, d, e);
        @(posedge clk_i);
        chk("sec reset off", 32'h1, sec_bus_reset_n_o);
        chk("fast b2b off", 32'h0, fast_b2b_en_o);
        apb(1'b0, 12'h100, 32'h0, d, e);
        chk("unmapped err", 32'h1, e);
        chk("unmapped data", 32'h0, d);
        $display("test ctrl done");
    endtask
    // One delayed request on side s, discarded or repeated
    task automatic t_tmo(input int s, input logic sh, input logic en, input logic [15:0] rp,
                         input logic [1:0] mk);
        logic [31:0] cw, d;
        logic e;
        int n, lim;
        cw = {4'h0, en, 1'b0, sh && s == 1, sh && s == 0, 2'b00, 22'h0};
        lim = sh ? SCYC : LCYC;
        n = 0;
        apb(1'b1, `BCU_OFF_CTRL, cw, d, e);
        apb(1'b1, `BCU_OFF_IRQ_MASK, {30'h0, mk}, d, e);
        rep_dly <= rp;
        start <= 2'b01 << s;
        @(posedge clk_i);
        start <= 2'b00;
        @(posedge clk_i);
        chk("head up", 32'h1, dt_head[s]);
        while (dt_discard[s] !== 1'b1 && n < lim + 8) begin
            @(posedge clk_i);
            n++;
        end
        if (rp != 16'h0000) begin
            chk("no discard", lim + 8, n);
        end else begin
            chk("discard delay", lim + 1, n);
            chk("serr pin", !en, primary_system_error_out_n_o);
            chk("irq pin", mk[s], irq_o);
            apb(1'b0, `BCU_OFF_CTRL, 32'h0, d, e);
            chk("tmo status", cw | 32'h0400_0000, d);
            apb(1'b1, `BCU_OFF_CTRL, cw | 32'h0400_0000, d, e);
            apb(1'b0, `BCU_OFF_CTRL, 32'h0, d, e);
            chk("tmo cleared", cw, d);
            apb(1'b0, `BCU_OFF_IRQ_STAT, 32'h0, d, e);
            chk("irq status", 32'h1 << s, d);
            chk("irq after read", 32'h0, irq_o);
            apb(1'b0, `BCU_OFF_IRQ_STAT, 32'h0, d, e);
            chk("irq status clear", 32'h0, d);
        end
        $display("test timeout side %0d done", s);
    endtask
    // ==========
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        t_ctrl();
        t_tmo(0, 1'b0, 1'b1, 16'h0000, 2'b01);
        t_tmo(1, 1'b1, 1'b0, 16'h0000, 2'b00);
        t_tmo(1, 1'b0, 1'b1, 16'h0000, 2'b10);
        t_tmo(0, 1'b1, 1'b0, 16'h0000, 2'b11);
        t_tmo(0, 1'b1, 1'b1, 16'h0005, 2'b01);
        t_tmo(1, 1'b0, 1'b1, 16'h0014, 2'b10);
        close_out();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        $display("watchdog expired");
        close_out();
    end
endmodule
`default_nettype wire
